// ---- core/dcvic_top.sv ----
// chained pair of vectored controllers with fast and vectored requests
`timescale 1ns/1ns
module dcvic_top #(
    parameter int N = dcvic_pkg::CHANNELS
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic [N-1:0]               irq_in,
    input  wire logic [N-1:0]               soft_req,
    input  wire logic [N-1:0]               chan_en,
    input  wire logic [N-1:0]               chan_fast,
    input  wire logic [N*dcvic_pkg::SUB_IDW-1:0] chan_src,
    input  wire logic [N*dcvic_pkg::VECW-1:0]    vec_addr,
    output logic                            fast_nonvectored_request,
    output logic                            vectored_request,
    output logic [dcvic_pkg::IDW-1:0]       service_routine_source,
    output logic [dcvic_pkg::VECW-1:0]      service_routine_vector
);
    localparam int H  = dcvic_pkg::SUB_CH;
    localparam int IW = dcvic_pkg::SUB_IDW;
    localparam int VW = dcvic_pkg::VECW;

    logic [N-1:0] req_s1_q, req_s2_q, req_s1_d, req_s2_d;
    logic         fast_q, fast_d, vec_q, vec_d;
    logic [dcvic_pkg::IDW-1:0] id_q, id_d;
    logic [VW-1:0] va_q, va_d;
    logic          p_vec, p_fast, s_vec, s_fast;
    logic [IW-1:0] p_chan, p_src, s_chan, s_src;
    logic [N-1:0]  src_all;
    logic [H-1:0]  p_own;
    logic          p_own_any;

    // two-stage sampling: irq inputs may come from other domains
    always_comb begin
        req_s1_d = irq_in;
        req_s2_d = req_s1_q;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            req_s1_q <= '0;
            req_s2_q <= '0;
        end else begin
            req_s1_q <= req_s1_d;
            req_s2_q <= req_s2_d;
        end
    end

    // software forcing is same-domain, merged after the synchroniser
    assign src_all = req_s2_q | soft_req;

    // primary's own vectored channels, seen apart from the chain input;
    // the chained any-request cannot tell whether the primary itself has one,
    // and a remapped channel listens to another source bit than its own index
    genvar g;
    generate
        for (g = 0; g < H; g++) begin : g_own
            assign p_own[g] = src_all[chan_src[g*IW +: IW]] & chan_en[g] & ~chan_fast[g];
        end
    endgenerate
    assign p_own_any = |p_own;

    // secondary feeds its any-request into the primary chain input;
    // sources never cross controllers, each instance sees only its half
    // limitation: the fast request is a plain or, it names no source
    dcvic_sub_ctrl #(.N(H), .IW(IW)) u_secondary_irq_controller (
        .src_req  (src_all[N-1:H]),
        .chan_src (chan_src[N*IW-1:H*IW]),
        .chan_en  (chan_en[N-1:H]),
        .chan_fast(chan_fast[N-1:H]),
        .chain_in (1'b0),
        .vec_any  (s_vec),
        .fast_any (s_fast),
        .win_chan (s_chan),
        .win_src  (s_src)
    );

    dcvic_sub_ctrl #(.N(H), .IW(IW)) u_primary_irq_controller (
        .src_req  (src_all[H-1:0]),
        .chan_src (chan_src[H*IW-1:0]),
        .chan_en  (chan_en[H-1:0]),
        .chan_fast(chan_fast[H-1:0]),
        .chain_in (s_vec),
        .vec_any  (p_vec),
        .fast_any (p_fast),
        .win_chan (p_chan),
        .win_src  (p_src)
    );

    // resolve winner; primary channel request beats any secondary one
    always_comb begin
        fast_d = p_fast | s_fast;
        vec_d  = p_vec;
        id_d   = dcvic_pkg::ID_RESET;
        va_d   = dcvic_pkg::VEC_RESET;
        // primary holds no own request when it only reflects the chain
        if (p_own_any) begin
            id_d = {1'b0, p_src};
            va_d = vec_addr[{1'b0, p_chan}*VW +: VW];
        end else if (s_vec) begin
            id_d = {1'b1, s_src};
            va_d = vec_addr[{1'b1, s_chan}*VW +: VW];
        end
        if (!vec_d) begin
            id_d = dcvic_pkg::ID_RESET;
            va_d = dcvic_pkg::VEC_RESET;
        end
    end

    // registered outputs; reset forces both requests low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fast_q <= 1'b0;
            vec_q  <= 1'b0;
            id_q   <= dcvic_pkg::ID_RESET;
            va_q   <= dcvic_pkg::VEC_RESET;
        end else begin
            fast_q <= fast_d;
            vec_q  <= vec_d;
            id_q   <= id_d;
            va_q   <= va_d;
        end
    end

    assign fast_nonvectored_request = fast_q;
    assign vectored_request         = vec_q;
    assign service_routine_source   = id_q;
    assign service_routine_vector   = va_q;

    // assertions
    // checks look one edge after their cause, since every output is registered;
    // the first edge after reset is skipped where the past still holds reset
    a_reset_quiet: assert property (@(posedge clock) rst |-> ##1
        (!fast_nonvectored_request || rst))
        else $error("fast request high under reset");

    a_reset_vec_low: assert property (@(posedge clock) rst |-> ##1
        (!vectored_request || rst))
        else $error("vectored request high under reset");

    a_soft_force: assert property (@(posedge clock) disable iff (rst)
        (soft_req[0] && chan_en[0] && !chan_fast[0] && chan_src[IW-1:0] == '0)
        |=> vectored_request)
        else $error("forced request not raised");

    a_disabled_quiet: assert property (@(posedge clock) disable iff (rst)
        (chan_en == '0) |=> !vectored_request && !fast_nonvectored_request)
        else $error("disabled channels raised a request");

    // the reset value stands at the first edge, whatever the chain showed before
    a_vec_or: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> vectored_request == $past(p_vec))
        else $error("vectored request not the channel or");

    a_primary_wins: assert property (@(posedge clock) disable iff (rst)
        (vectored_request && service_routine_source[dcvic_pkg::IDW-1])
        |-> !$past(p_own_any))
        else $error("secondary won over primary");

    a_idle_ids: assert property (@(posedge clock) disable iff (rst)
        !vectored_request |-> service_routine_source == dcvic_pkg::ID_RESET)
        else $error("source shown with no request");

    a_idle_vector: assert property (@(posedge clock) disable iff (rst)
        !vectored_request |-> service_routine_vector == dcvic_pkg::VEC_RESET)
        else $error("vector shown with no request");

    a_ch0_top: assert property (@(posedge clock) disable iff (rst)
        (src_all[0] && chan_en[0] && !chan_fast[0] && chan_src[IW-1:0] == '0)
        |=> service_routine_source == '0)
        else $error("channel zero did not win");

    // channel 0 listening to source 0 and steered to the fast request
    sequence s_ch0_fast;
        src_all[0] && chan_en[0] && chan_fast[0] && chan_src[IW-1:0] == '0;
    endsequence
    a_fast_route: assert property (@(posedge clock) disable iff (rst)
        s_ch0_fast |=> fast_nonvectored_request)
        else $error("fast routing failed");

    a_all_fast: assert property (@(posedge clock) disable iff (rst)
        (chan_fast == '1) |=> !vectored_request)
        else $error("fast-routed channel reached the vectored request");

    a_fast_no_id: assert property (@(posedge clock) disable iff (rst)
        (fast_nonvectored_request && !vectored_request)
        |-> service_routine_source == dcvic_pkg::ID_RESET)
        else $error("fast request carried a source");

    // first secondary channel on its own local source reaches the core via the chain
    a_chain_reach: assert property (@(posedge clock) disable iff (rst)
        (src_all[H] && chan_en[H] && !chan_fast[H] && chan_src[H*IW +: IW] == '0)
        |=> vectored_request)
        else $error("secondary request lost in the chain");

    // three quiet samples drain both synchroniser stages and the output flops
    sequence s_inputs_quiet;
        (irq_in == '0 && soft_req == '0) [*3];
    endsequence
    a_quiet_drain: assert property (@(posedge clock) disable iff (rst)
        s_inputs_quiet |=> !vectored_request && !fast_nonvectored_request)
        else $error("request left standing after inputs went quiet");
endmodule

// ---- core/dcvic_pkg.sv ----
// shared constants for the chained vectored interrupt controller
package dcvic_pkg;
    localparam int CHANNELS   = 32;
    localparam int SUB_CH     = 16;
    localparam int SUB_IDW    = 4;
    localparam int IDW        = 5;
    localparam int VECW       = 32;
    localparam logic [IDW-1:0]  ID_RESET  = 5'h00;
    localparam logic [VECW-1:0] VEC_RESET = 32'h00000000;
endpackage

// ---- core/dcvic_sub_ctrl.sv ----
// one sixteen-channel vectored controller with source remap and chain input
`timescale 1ns/1ns
module dcvic_sub_ctrl #(
    parameter int N  = dcvic_pkg::SUB_CH,
    parameter int IW = dcvic_pkg::SUB_IDW
) (
    input  wire logic [N-1:0]    src_req,
    input  wire logic [N*IW-1:0] chan_src,
    input  wire logic [N-1:0]    chan_en,
    input  wire logic [N-1:0]    chan_fast,
    input  wire logic            chain_in,
    output logic                 vec_any,
    output logic                 fast_any,
    output logic [IW-1:0]        win_chan,
    output logic [IW-1:0]        win_src
);
    logic [N-1:0] chan_req;

    // each hardware channel listens to whichever local source it was mapped to
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chan
            assign chan_req[g] = src_req[chan_src[g*IW +: IW]] & chan_en[g];
        end
    endgenerate

    // lowest channel wins; the chained lower controller sits below channel N-1
    always_comb begin
        vec_any  = chain_in;
        fast_any = 1'b0;
        win_chan = '0;
        win_src  = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (chan_req[i] && chan_fast[i]) begin
                fast_any = 1'b1;
            end
            if (chan_req[i] && !chan_fast[i]) begin
                vec_any  = 1'b1;
                win_chan = IW'(i);
                win_src  = chan_src[i*IW +: IW];
            end
        end
    end
endmodule

// ---- tb/dcvic_core_model.sv ----
// processor core stand-in taking the fast and vectored requests
`timescale 1ns/1ns
module dcvic_core_model (
    input  wire logic                        clock,
    input  wire logic                        fast_req,
    input  wire logic                        vec_req,
    input  wire logic [dcvic_pkg::IDW-1:0]   src,
    input  wire logic [dcvic_pkg::VECW-1:0]  vec,
    output logic      [dcvic_pkg::IDW-1:0]   taken_src,
    output logic      [dcvic_pkg::VECW-1:0]  taken_vec
);
    // fast entry skips the read, so only a vectored entry reads source and vector
    always_ff @(posedge clock) begin
        if (vec_req && !fast_req) begin
            taken_src <= src;
            taken_vec <= vec;
        end
    end
endmodule

// ---- tb/dcvic_top_tb.sv ----
// self-checking bench for the chained vectored interrupt controller
`timescale 1ns/1ns
module dcvic_top_tb;
    logic         clock = 0;
    logic         rst = 1;
    logic [31:0]  irq_in = '0, soft_req = '1, chan_en = '1, chan_fast = '0;
    logic [127:0] chan_src;
    logic [1023:0] vec_addr;
    logic         fq, vq;
    logic [4:0]   src, t_src;
    logic [31:0]  vec, t_vec;
    int           n_errors = 0, checked = 0;
    always #20 clock = ~clock;
    dcvic_top dut (.clock(clock), .rst(rst), .irq_in(irq_in), .soft_req(soft_req),
        .chan_en(chan_en), .chan_fast(chan_fast), .chan_src(chan_src), .vec_addr(vec_addr),
        .fast_nonvectored_request(fq), .vectored_request(vq),
        .service_routine_source(src), .service_routine_vector(vec));
    dcvic_core_model core (.clock(clock), .fast_req(fq), .vec_req(vq), .src(src),
        .vec(vec), .taken_src(t_src), .taken_vec(t_vec));
    // vector table with a distinct address per channel
    function automatic logic [31:0] va(int i);
        return 32'h00008000 + 32'(i) * 32'h00000010;
    endfunction
    task step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // compares all four outputs; idle source and vector must read zero
    task expect_out(logic ef, logic ev, int ch, logic [4:0] es);
        checked++;
        if (fq !== ef || vq !== ev || src !== (ev ? es : 5'h00)
            || vec !== (ev ? va(ch) : 32'h00000000)) begin
            n_errors++;
            $display("unexpected at %0t: outputs f=%b v=%b s=%h", $time, fq, vq, src);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task t_reset;
        step(1);
        expect_out(0, 0, 0, 0);
        step(1);
        rst = 0;
        soft_req = '0;
        step(2);
    endtask
    task t_latency;
        irq_in[3] = 1;
        step(2);
        expect_out(0, 0, 0, 0);
        step(1);
        expect_out(0, 1, 3, 5'h03);
        step(1);
        checked++;
        if (t_src !== 5'h03 || t_vec !== va(3)) begin
            n_errors++;
            $display("unexpected at %0t: core read wrong entry", $time);
        end
        irq_in = '0;
        step(3);
    endtask
    task t_prio;
        soft_req = 32'h00000084;
        step(1);
        expect_out(0, 1, 2, 5'h02);
        soft_req = 32'h80018000;
        step(1);
        expect_out(0, 1, 15, 5'h0F);
        soft_req = 32'h80010000;
        step(1);
        expect_out(0, 1, 16, 5'h10);
        soft_req = '0;
        step(1);
        expect_out(0, 0, 0, 0);
    endtask
    task t_enable_fast;
        chan_en[4] = 0;
        chan_fast[4] = 1;
        soft_req[4] = 1;
        step(1);
        expect_out(0, 0, 0, 0);
        chan_en[4] = 1;
        chan_fast[4] = 0;
        chan_fast[20] = 1;
        soft_req = 32'h02100000;
        step(1);
        expect_out(1, 1, 25, 5'h19);
        soft_req = 32'h00100000;
        step(1);
        expect_out(1, 0, 0, 0);
        chan_fast = '0;
        soft_req = '0;
        step(1);
    endtask
    task t_remap;
        chan_src[3:0] = 4'h5;
        chan_src[23:20] = 4'h0;
        soft_req = 32'h00000020;
        step(1);
        expect_out(0, 1, 0, 5'h05);
        chan_en[5] = 0;
        soft_req = 32'h00010020;
        step(1);
        expect_out(0, 1, 0, 5'h05);
        chan_en[5] = 1;
        soft_req = '0;
        step(1);
    endtask
    initial begin
        for (int i = 0; i < 32; i++) begin
            chan_src[i*4 +: 4] = 4'(i % 16);
            vec_addr[i*32 +: 32] = va(i);
        end
        #1;
        t_reset;
        t_latency;
        t_prio;
        t_enable_fast;
        t_remap;
        finish_test;
    end
endmodule
